// ==== rlr_exec.sv ====
/*
 * Executor for two instructions of an 8-bit core: return-with-literal and
 * rotate-right-through-carry.
 * Assumes the fetch unit presents one instruction per cycle on core_clk, the
 * register file returns the addressed file register combinationally, and the
 * stack presents its top entry combinationally.
 */
// How it works
// (RQ1) Return-with-literal loads its eight-bit literal into the working register.
// (RQ2) Return-with-literal reloads the program counter from the stack top.
// (RQ3) Return-with-literal takes two cycles; the following fetch is discarded.
// (RQ4) Rotate decodes 0011 00df ffff; carry enters bit 7, bit 0 enters carry.
// (RQ5) Rotate changes only the carry among the status bits.
// (RQ6) With d zero the result goes to the working register only.
// (RQ7) With d one the result is written back to the file register.
// (RQ8) Rotate finishes in one cycle, destination and carry updating together.
`timescale 1ns/1ps

module rlr_exec (
	input  wire logic                        core_clk,
	input  wire logic                        resetn,
	input  wire rlr_pkg::rlr_instr_s         instr,
	input  wire logic [rlr_pkg::PC_W-1:0]    stack_top,
	input  wire logic [rlr_pkg::DATA_W-1:0]  f_rdata,
	input  wire logic                        carry_in,
	output logic      [rlr_pkg::FADDR_W-1:0] f_raddr,
	output logic      [rlr_pkg::DATA_W-1:0]  w_out,
	output logic                             carry_out,
	output logic      [rlr_pkg::PC_W-1:0]    pc_out,
	output logic                             pc_load,
	output logic                             stack_pop,
	output logic                             discard,
	output rlr_pkg::rlr_fwrite_s             fwrite,
	output logic                             busy
);

	rlr_pkg::rlr_state_s state_ff;
	rlr_pkg::rlr_state_s nxt_state;

	logic is_retlit;
	logic is_rot;
	logic dest_f;
	logic [rlr_pkg::DATA_W-1:0] rot_result;

	// An instruction arriving during the flush cycle is the discarded fetch.
	assign is_retlit = instr.valid && (state_ff.state == rlr_pkg::RLR_IDLE) &&
		(instr.word[rlr_pkg::INSTR_W-1:rlr_pkg::OPC_RETLIT_LSB] == rlr_pkg::OPC_RETLIT);
	assign is_rot = instr.valid && (state_ff.state == rlr_pkg::RLR_IDLE) &&
		(instr.word[rlr_pkg::INSTR_W-1:rlr_pkg::OPC_ROT_LSB] == rlr_pkg::OPC_ROTRIGHT); // RQ4
	assign dest_f     = instr.word[rlr_pkg::DEST_BIT];
	assign f_raddr    = instr.word[rlr_pkg::FADDR_W-1:0];
	assign rot_result = {carry_in, f_rdata[rlr_pkg::DATA_W-1:1]}; // RQ4

	always_comb begin
		nxt_state         = state_ff;
		nxt_state.pc_load = 1'b0;
		nxt_state.discard = 1'b0;
		nxt_state.fw.f_we = 1'b0;
		nxt_state.carry   = carry_in;
		case (state_ff.state)
			rlr_pkg::RLR_IDLE: begin
				if (is_retlit) begin
					nxt_state.w       = instr.word[rlr_pkg::DATA_W-1:0]; // RQ1
					nxt_state.pc      = stack_top; // RQ2
					nxt_state.pc_load = 1'b1; // RQ2
					nxt_state.state   = rlr_pkg::RLR_FLUSH; // RQ3
				end else if (is_rot) begin
					// Carry and destination commit at the same edge.
					nxt_state.carry = f_rdata[0]; // RQ4 RQ5 RQ8
					if (dest_f) begin
						nxt_state.fw.f_we    = 1'b1; // RQ7
						nxt_state.fw.f_addr  = f_raddr; // RQ7
						nxt_state.fw.f_wdata = rot_result; // RQ7
					end else begin
						nxt_state.w = rot_result; // RQ6
					end
				end
			end
			rlr_pkg::RLR_FLUSH: begin
				nxt_state.discard = 1'b1; // RQ3
				nxt_state.state   = rlr_pkg::RLR_IDLE; // RQ3
			end
			default: begin
				nxt_state.state = rlr_pkg::RLR_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_ff.state      <= rlr_pkg::RLR_IDLE;
			state_ff.w          <= rlr_pkg::W_RESET;
			state_ff.carry      <= 1'b0;
			state_ff.pc         <= rlr_pkg::PC_RESET;
			state_ff.pc_load    <= 1'b0;
			state_ff.discard    <= 1'b0;
			state_ff.fw.f_we    <= 1'b0;
			state_ff.fw.f_addr  <= '0;
			state_ff.fw.f_wdata <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign w_out     = state_ff.w;
	assign carry_out = state_ff.carry;
	assign pc_out    = state_ff.pc;
	assign pc_load   = state_ff.pc_load;
	assign stack_pop = state_ff.pc_load;
	assign discard   = state_ff.discard;
	assign fwrite    = state_ff.fw;
	assign busy      = (state_ff.state == rlr_pkg::RLR_FLUSH);

endmodule : rlr_exec

// ==== rlr_exec_assertions.sv ====
/* Port checker bound to rlr_exec; assumes one clock. */
`timescale 1ns/1ps
module rlr_chk (
	input wire logic core_clk, resetn, carry_in, carry_out, pc_load, stack_pop, discard, busy,
	input wire logic [8:0] stack_top, pc_out, input wire logic [7:0] f_rdata, w_out,
	input wire rlr_pkg::rlr_instr_s instr, input wire rlr_pkg::rlr_fwrite_s fwrite);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	wire rt = instr.valid && !busy && instr.word[11:8] == 4'h8;
	wire rr = instr.valid && !busy && instr.word[11:6] == 6'h0C;
	wire [7:0] res = {carry_in, f_rdata[7:1]};
	sequence s_ret; stack_pop && busy ##1 discard && !busy; endsequence
	property p_w; rt |=> w_out == $past(instr.word[7:0]); endproperty
	a_w: assert property (p_w) else $error("w");
	property p_pc; rt |=> pc_out == $past(stack_top); endproperty
	a_pc: assert property (p_pc) else $error("pc");
	property p_two; rt |=> s_ret; endproperty
	a_two: assert property (p_two) else $error("two");
	property p_c; rr |=> carry_out == $past(f_rdata[0]); endproperty
	a_c: assert property (p_c) else $error("c");
	property p_k; rr |=> !pc_load && $stable(pc_out); endproperty
	a_k: assert property (p_k) else $error("k");
	property p_d0; rr && !instr.word[5] |=> !fwrite.f_we && w_out == $past(res); endproperty
	a_d0: assert property (p_d0) else $error("d0");
	property p_d1; rr && instr.word[5] |=> fwrite.f_we && fwrite.f_wdata == $past(res); endproperty
	a_d1: assert property (p_d1) else $error("d1");
	property p_one; rr |=> !busy && !discard; endproperty
	a_one: assert property (p_one) else $error("one");
endmodule : rlr_chk
bind rlr_exec rlr_chk u_chk (.*);

// ==== rlr_pkg.sv ====
/*
 * Package for the return-with-literal and rotate-right-through-carry executor.
 * Assumes a 12-bit instruction word and an 8-bit data path.
 */
package rlr_pkg;

	localparam int          INSTR_W         = 12;
	localparam int          DATA_W          = 8;
	localparam int          FADDR_W         = 5;
	localparam int          PC_W            = 9;
	localparam logic [3:0]  OPC_RETLIT      = 4'h8;
	localparam logic [5:0]  OPC_ROTRIGHT    = 6'h0C;
	localparam int          OPC_RETLIT_LSB  = 8;
	localparam int          OPC_ROT_LSB     = 6;
	localparam int          DEST_BIT        = 5;
	localparam logic [7:0]  W_RESET         = 8'h00;
	localparam logic [8:0]  PC_RESET        = 9'h000;

	typedef enum logic [1:0] {
		RLR_IDLE,
		RLR_FLUSH
	} rlr_state_e;

	typedef struct packed {
		logic              valid;
		logic [INSTR_W-1:0] word;
	} rlr_instr_s;

	typedef struct packed {
		logic              f_we;
		logic [FADDR_W-1:0] f_addr;
		logic [DATA_W-1:0]  f_wdata;
	} rlr_fwrite_s;

	typedef struct packed {
		rlr_state_e         state;
		logic [DATA_W-1:0]  w;
		logic               carry;
		logic [PC_W-1:0]    pc;
		logic               pc_load;
		logic               discard;
		rlr_fwrite_s        fw;
	} rlr_state_s;

endpackage : rlr_pkg

// ==== testbench.sv ====
/* Random bench for rlr_exec with a cycle model. */
`timescale 1ns/1ps
module testbench;
	logic core_clk = 0, resetn = 0, carry_in = 0, mc = 0, mb = 0;
	logic carry_out, pc_load, stack_pop, discard, busy;
	logic [8:0] stack_top = '0, pc_out;
	logic [7:0] f_rdata = '0, w_out, mw = '0;
	logic [8:0] mp = '0;
	logic mpl = 0, md = 0;
	logic [13:0] mfw = '0;
	logic [4:0] f_raddr;
	rlr_pkg::rlr_instr_s instr = '0;
	rlr_pkg::rlr_fwrite_s fwrite;
	int bad_count, samples_checked;
	always #5 core_clk = ~core_clk;
	rlr_exec uut (.*);
	task final_report;
		if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report
	initial begin
		void'($urandom(70));
		repeat (10) @(posedge core_clk);
		resetn <= 1;
		repeat (2000) begin
			@(posedge core_clk);
			mc = carry_in;
			md = mb;
			mpl = 0;
			mfw[13] = 0;
			if (mb) mb = 0;
			else if (instr.valid && instr.word[11:8] == 4'h8) begin
				{mw, mb} = {instr.word[7:0], 1'h1};
				{mp, mpl} = {stack_top, 1'h1};
			end else if (instr.valid && instr.word[11:6] == 6'h0C) begin
				{mc, mw} = {f_rdata[0], instr.word[5] ? mw : {carry_in, f_rdata[7:1]}};
				if (instr.word[5]) mfw = {1'h1, instr.word[4:0], carry_in, f_rdata[7:1]};
			end
			instr <= {1'($urandom), $urandom % 2 ? 4'h8 : 4'h3, 8'($urandom)};
			{stack_top, f_rdata, carry_in} <= 18'($urandom);
			#1 samples_checked++;
			if ({w_out, carry_out, busy, pc_out, pc_load, stack_pop, discard, fwrite} !== {mw, mc, mb, mp, mpl, mpl, md, mfw}) begin
				bad_count++;
				$display("CHECK FAILED %0t %h %h", $time, {w_out, carry_out, busy, pc_out, pc_load, stack_pop, discard, fwrite}, {mw, mc, mb, mp, mpl, mpl, md, mfw});
			end
		end
		final_report();
	end
endmodule : testbench
